/* dv/msp_lp_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Link partner and media engines
module msp_partner_model (
  // Clock
  input  wire logic                core_clk,
  // Scenario controls
  input  wire logic                cu_up,
  input  wire logic                sd_up,
  input  wire logic                loop_en,
  input  wire logic                energy_on,
  // Device status seen by the media side
  input  wire msp_pkg::msp_stat_t  stat,
  // Link engines and media pins toward the device
  output var msp_pkg::msp_media_t  media,
  output logic                     energy_det
);
  import msp_pkg::*;

  logic loop_r = 1'b0;

  // Powered-down partner echoes pulses one clock later
  always_ff @(posedge core_clk) begin
    loop_r <= loop_en & stat.ipd_flp_tx;
  end

  // A blocked medium cannot hold its link
  always_comb begin
    media.cu_link      = cu_up & ~stat.cu_block;
    media.sd_link      = sd_up & ~stat.sd_block;
    media.flp_loopback = loop_r;
  end

  // Energy pin follows the partner's activity
  assign energy_det = energy_on;
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin mismatches++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
// ==========================================
// Self-checking bench for the link management core
module tb_top;
  import msp_pkg::*;

  localparam int MSC   = 4;
  localparam int LIMIT = 40000;

  logic       core_clk  = 1'b0;
  logic       reset_n   = 1'b0;
  msp_cfg_t   cfg       = '0;
  logic       int_rd    = 1'b0;
  logic       cu_up     = 1'b0;
  logic       sd_up     = 1'b0;
  logic       loop_en   = 1'b0;
  logic       energy_on = 1'b0;
  msp_media_t media;
  logic       energy_det;
  msp_stat_t  stat;
  int         mismatches  = 0;
  int         checks_done = 0;
  int         cyc         = 0;
  int         n;
  int         bursts;
  logic       pb;
  logic [1:0] ex;
  logic [2:0] m;
  logic [2:0] modes [4] = '{MODE_AUTO_ANEG, MODE_AUTO_PASS, MODE_AUTO_FX, 3'h0};

  // Clock generator
  always #25 core_clk = ~core_clk;

  msp_core #(.MS_CYCLES(MSC)) uut (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .cfg        (cfg),
    .int_rd     (int_rd),
    .media      (media),
    .energy_det (energy_det),
    .stat       (stat)
  );

  msp_partner_model partner (
    .core_clk   (core_clk),
    .cu_up      (cu_up),
    .sd_up      (sd_up),
    .loop_en    (loop_en),
    .energy_on  (energy_on),
    .stat       (stat),
    .media      (media),
    .energy_det (energy_det)
  );

  // Selection mode test
  function automatic logic is_auto(input logic [2:0] md);
    return md == MODE_AUTO_ANEG || md == MODE_AUTO_PASS || md == MODE_AUTO_FX;
  endfunction

  // Expected medium from mode, preference and links
  function automatic logic [1:0] pick(input logic [2:0] md, input logic p, input logic c, input logic s);
    if (!is_auto(md)) return c ? MEDIA_COPPER : MEDIA_NONE;
    if (p) return s ? MEDIA_SERDES : (c ? MEDIA_COPPER : MEDIA_NONE);
    return c ? MEDIA_COPPER : (s ? MEDIA_SERDES : MEDIA_NONE);
  endfunction

  // Verdict and end of run
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task cycles(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  // Bounded waits on power state and detection status
  task wait_pwr(input msp_ps_e_t s, input int lim, output int cnt);
    cnt = 0;
    while (stat.pwr_state !== s && cnt < lim) begin
      @(negedge core_clk);
      cnt++;
    end
  endtask

  task wait_ipd(input logic [1:0] s, input int lim, output int cnt);
    cnt = 0;
    while (stat.ipd_status !== s && cnt < lim) begin
      @(negedge core_clk);
      cnt++;
    end
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      finish_test();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(negedge core_clk);
    `CHK("active_rst", MEDIA_NONE, stat.active_media)
    `CHK("pwr_rst", PS_OFF, stat.pwr_state)
    reset_n = 1'b1;
    // Media selection over the three auto modes and mode 0, both preferences and all link sets
    for (int mi = 0; mi < 4; mi++) begin
      for (int p = 0; p < 2; p++) begin
        m = modes[mi];
        cfg.media_mode  = m;
        cfg.pref_serdes = p[0];
        for (int k = 0; k < 4; k++) begin
          {sd_up, cu_up} = k[1:0];
          #1;
          ex = pick(m, p[0], media.cu_link, media.sd_link);
          @(negedge core_clk);
          `CHK("active_1cyc", ex, stat.active_media)
          cycles(3);
          ex = pick(m, p[0], cu_up, sd_up);
          `CHK("active", ex, stat.active_media)
          `CHK("link", ex != MEDIA_NONE, stat.link_status)
          `CHK("cu_block", is_auto(m) & p[0] & (ex == MEDIA_SERDES), stat.cu_block)
          `CHK("sd_block", is_auto(m) & ~p[0] & (ex == MEDIA_COPPER), stat.sd_block)
          `CHK("regs_both", is_auto(m) & (m != MODE_AUTO_PASS), stat.regs_both)
        end
        {sd_up, cu_up} = 2'h0;
        cycles(3);
      end
    end
    // Inline power detection
    cfg.media_mode  = MODE_AUTO_ANEG;
    cfg.pref_serdes = 1'b0;
    cfg.ipd_en      = 1'b1;
    cycles(3);
    `CHK("flp_no_aneg", 1'b0, stat.ipd_flp_tx)
    cfg.aneg_en = 1'b1;
    cycles(2);
    `CHK("flp_tx", 1'b1, stat.ipd_flp_tx)
    `CHK("ipd_search", IPD_ST_SEARCH, stat.ipd_status)
    wait_ipd(IPD_ST_TIMEOUT, (int'(IPD_TIMEOUT_MS) + 3) * MSC, n);
    `CHK("ipd_to_time", 1'b1, n >= (int'(IPD_TIMEOUT_MS) - 2) * MSC)
    `CHK("ipd_to", IPD_ST_TIMEOUT, stat.ipd_status)
    `CHK("flp_off", 1'b0, stat.ipd_flp_tx)
    `CHK("aneg_run", 1'b1, stat.aneg_run)
    cu_up = 1'b1;
    cycles(3);
    `CHK("link_up", 1'b1, stat.link_status)
    cu_up = 1'b0;
    cycles(3);
    `CHK("ipd_restart", IPD_ST_SEARCH, stat.ipd_status)
    `CHK("flp_again", 1'b1, stat.ipd_flp_tx)
    loop_en = 1'b1;
    wait_ipd(IPD_ST_FOUND, 10, n);
    `CHK("ipd_found", IPD_ST_FOUND, stat.ipd_status)
    `CHK("ipd_flag", 1'b1, stat.ipd_flag)
    // Switch powers the device, echo stops
    loop_en = 1'b0;
    cycles(3);
    `CHK("flag_sticky", 1'b1, stat.ipd_flag)
    int_rd = 1'b1;
    @(negedge core_clk);
    int_rd = 1'b0;
    @(negedge core_clk);
    `CHK("flag_clr", 1'b0, stat.ipd_flag)
    cfg.ipd_en = 1'b0;
    cycles(3);
    // Power saving cycle
    cfg.sleep_sel  = 2'h1;
    cfg.wake_sel   = 2'h1;
    cfg.lsto_sel   = 2'h1;
    cfg.psave_en   = 1'b1;
    cycles(2);
    `CHK("ps_low", PS_LOW, stat.pwr_state)
    wait_pwr(PS_WAKE, (int'(SLEEP_MS[1]) + 64) * MSC, n);
    `CHK("sleep_time", 1'b1, n >= (int'(SLEEP_MS[1]) - 82) * MSC)
    `CHK("ps_wake", PS_WAKE, stat.pwr_state)
    n = 0;
    bursts = 0;
    pb = 1'b0;
    while (stat.pwr_state === PS_WAKE && n < 2 * int'(WAKE_MS[1]) * MSC) begin
      if (stat.wake_flp === 1'b1) begin
        if (bursts > 0) `CHK("pair_alt", ~pb, stat.wake_pair_b)
        pb = stat.wake_pair_b;
        bursts++;
      end
      @(negedge core_clk);
      n++;
    end
    `CHK("bursts", 3, bursts)
    `CHK("wake_time", 1'b1, n >= (int'(WAKE_MS[1]) - 2) * MSC && n <= (int'(WAKE_MS[1]) + 2) * MSC)
    `CHK("back_low", PS_LOW, stat.pwr_state)
    energy_on = 1'b1;
    wait_pwr(PS_NORM, 6, n);
    `CHK("energy_norm", PS_NORM, stat.pwr_state)
    energy_on = 1'b0;
    wait_pwr(PS_LOW, (int'(LSTO_MS[1]) + 3) * MSC, n);
    `CHK("lsto_time", 1'b1, n >= (int'(LSTO_MS[1]) - 3) * MSC)
    `CHK("lsto_low", PS_LOW, stat.pwr_state)
    // Auto-negotiation off while in normal state
    energy_on = 1'b1;
    wait_pwr(PS_NORM, 6, n);
    energy_on   = 1'b0;
    cfg.aneg_en = 1'b0;
    cycles((int'(LSTO_MS[1]) + 100) * MSC);
    `CHK("stay_norm", PS_NORM, stat.pwr_state)
    // Mid-run reset with power saving still enabled
    reset_n = 1'b0;
    @(negedge core_clk);
    `CHK("pwr_mid_rst", PS_OFF, stat.pwr_state)
    `CHK("active_mid_rst", MEDIA_NONE, stat.active_media)
    reset_n = 1'b1;
    cycles(2);
    `CHK("low_after_rst", PS_LOW, stat.pwr_state)
    cfg.psave_en = 1'b0;
    cycles(2);
    `CHK("ps_off", PS_OFF, stat.pwr_state)
    finish_test();
  end
endmodule
`default_nettype wire

/* rtl/msp_core.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Media select, inline power detect and power saving
// How it works
// - preference bit picks copper or SerDes
// - preferred link wins, drops non-preferred link
// - lone non-preferred link stays until preempted/lost
// - SerDes preferred blocks copper while SerDes linked
// - two-bit status reports copper, SerDes, none
// - mode codes 110, 101, 111 enable selection
// - pass-through mode: registers show copper only
// - detection needs enable and auto-negotiation enable
// - search sends special pulses, status 00
// - loopback gives status 01 and flag
// - interrupt status read clears flag
// - no loopback by time limit gives 10
// - status 10 resumes auto-negotiation, link reported
// - link loss restarts detection search
// - power saving enable accepted any time
// - sleep and wake alternate until energy seen
// - link loss in normal returns after timeout
// - enabled power saving starts in low power
// - forced speed stays normal after energy
// - auto-negotiation off in normal: stay normal
// - low power watches energy, goes normal
// - sleep period by field, randomized -80/+60 ms
// - wake sends three bursts alternating pairs
// - link timeout period from selection field
module msp_core #(
  parameter int MS_CYCLES = msp_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  // Management configuration and interrupt status read
  input  wire msp_pkg::msp_cfg_t  cfg,
  input  wire logic               int_rd,
  // Link engines and media pins
  input  wire msp_pkg::msp_media_t media,
  input  wire logic               energy_det,
  // Status toward management and engines
  output msp_pkg::msp_stat_t      stat
);
  import msp_pkg::*;

  typedef struct packed {
    msp_stat_t  stat;
    msp_ipd_e_t ipd;
    logic [12:0] ipd_tmr;
    logic [12:0] ps_tmr;
    logic [4:0]  burst_tmr;
    logic [1:0]  burst_cnt;
    logic        link_seen;
    logic [2:0]  en_q;
    logic        energy;
  } msp_core_st_t;

  msp_core_st_t st_r;
  msp_core_st_t st_nxt;
  logic         ms_tick;
  logic [7:0]   rnd;
  logic         auto_sel;
  logic         ipd_ok;
  logic         ipd_set;
  logic [1:0]   act;
  logic         link;
  logic [12:0]  sleep_ld;

  // ========================================================
  // Time base and randomizer
  msp_tick_gen #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ms_tick  (ms_tick),
    .rnd      (rnd)
  );

  // Randomized sleep reload
  assign sleep_ld = 13'(SLEEP_MS[cfg.sleep_sel] + {5'h00, rnd} - RAND_NEG_MS);

  // ========================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    // Energy pin synchronizer, change once stages two and three agree
    st_nxt.en_q = {st_r.en_q[1:0], energy_det};
    if (st_r.en_q[1] == st_r.en_q[2]) begin
      st_nxt.energy = st_r.en_q[2];
    end

    // Automatic media selection
    auto_sel = (cfg.media_mode == MODE_AUTO_ANEG) || (cfg.media_mode == MODE_AUTO_PASS) ||
               (cfg.media_mode == MODE_AUTO_FX);
    act = st_r.stat.active_media;
    if (!auto_sel) begin
      act = media.cu_link ? MEDIA_COPPER : MEDIA_NONE;
    end else begin
      case (st_r.stat.active_media)
        MEDIA_COPPER: begin
          if (!media.cu_link) begin
            act = media.sd_link ? MEDIA_SERDES : MEDIA_NONE;
          end else if (cfg.pref_serdes && media.sd_link) begin
            act = MEDIA_SERDES;
          end
        end
        MEDIA_SERDES: begin
          if (!media.sd_link) begin
            act = media.cu_link ? MEDIA_COPPER : MEDIA_NONE;
          end else if (!cfg.pref_serdes && media.cu_link) begin
            act = MEDIA_COPPER;
          end
        end
        default: begin
          if (media.cu_link && media.sd_link) begin
            act = cfg.pref_serdes ? MEDIA_SERDES : MEDIA_COPPER;
          end else if (media.cu_link) begin
            act = MEDIA_COPPER;
          end else if (media.sd_link) begin
            act = MEDIA_SERDES;
          end else begin
            act = MEDIA_NONE;
          end
        end
      endcase
    end
    st_nxt.stat.active_media = act;
    st_nxt.stat.cu_block = auto_sel && cfg.pref_serdes && (act == MEDIA_SERDES);
    st_nxt.stat.sd_block = auto_sel && !cfg.pref_serdes && (act == MEDIA_COPPER);
    st_nxt.stat.regs_both = auto_sel && (cfg.media_mode != MODE_AUTO_PASS);
    link = ((act == MEDIA_COPPER) && media.cu_link) || ((act == MEDIA_SERDES) && media.sd_link);
    st_nxt.stat.link_status = link;

    // Inline powered device detection
    ipd_ok  = cfg.ipd_en && cfg.aneg_en;
    ipd_set = 1'b0;
    if (ms_tick && (st_r.ipd_tmr != 13'h0000)) begin
      st_nxt.ipd_tmr = st_r.ipd_tmr - 13'h0001;
    end
    case (st_r.ipd)
      IPD_OFF: begin
        if (ipd_ok) begin
          st_nxt.ipd     = IPD_SEARCH;
          st_nxt.ipd_tmr = IPD_TIMEOUT_MS;
        end
      end
      IPD_SEARCH, IPD_FOUND: begin
        if (!ipd_ok) begin
          st_nxt.ipd = IPD_OFF;
        end else if (media.flp_loopback) begin
          st_nxt.ipd     = IPD_FOUND;
          st_nxt.ipd_tmr = IPD_TIMEOUT_MS;
          ipd_set        = 1'b1;
        end else if (st_r.ipd_tmr == 13'h0000) begin
          st_nxt.ipd       = IPD_ANEG;
          st_nxt.link_seen = 1'b0;
        end
      end
      IPD_ANEG: begin
        if (!ipd_ok) begin
          st_nxt.ipd = IPD_OFF;
        end else if (st_r.link_seen && !media.cu_link) begin
          st_nxt.ipd     = IPD_SEARCH;
          st_nxt.ipd_tmr = IPD_TIMEOUT_MS;
        end else if (media.cu_link) begin
          st_nxt.link_seen = 1'b1;
        end
      end
      default: st_nxt.ipd = IPD_OFF;
    endcase
    case (st_nxt.ipd)
      IPD_FOUND: st_nxt.stat.ipd_status = IPD_ST_FOUND;
      IPD_ANEG:  st_nxt.stat.ipd_status = IPD_ST_TIMEOUT;
      default:   st_nxt.stat.ipd_status = IPD_ST_SEARCH;
    endcase
    st_nxt.stat.ipd_flp_tx = (st_nxt.ipd == IPD_SEARCH) || (st_nxt.ipd == IPD_FOUND);
    st_nxt.stat.aneg_run = cfg.aneg_en && !st_nxt.stat.ipd_flp_tx;
    // Set wins over a clearing read
    st_nxt.stat.ipd_flag = ipd_set || (st_r.stat.ipd_flag && !int_rd);

    // Power saving state machine
    st_nxt.stat.wake_flp = 1'b0;
    if (ms_tick && (st_r.ps_tmr != 13'h0000)) begin
      st_nxt.ps_tmr = st_r.ps_tmr - 13'h0001;
    end
    if (ms_tick && (st_r.burst_tmr != 5'h00)) begin
      st_nxt.burst_tmr = st_r.burst_tmr - 5'h01;
    end
    case (st_r.stat.pwr_state)
      PS_OFF: begin
        if (cfg.psave_en) begin
          st_nxt.stat.pwr_state = PS_LOW;
          st_nxt.ps_tmr         = sleep_ld;
        end
      end
      PS_LOW: begin
        if (!cfg.psave_en) begin
          st_nxt.stat.pwr_state = PS_OFF;
        end else if (st_r.energy) begin
          st_nxt.stat.pwr_state = PS_NORM;
          st_nxt.ps_tmr         = LSTO_MS[cfg.lsto_sel];
        end else if (st_r.ps_tmr == 13'h0000) begin
          st_nxt.stat.pwr_state = PS_WAKE;
          st_nxt.ps_tmr         = WAKE_MS[cfg.wake_sel];
          st_nxt.burst_tmr      = 5'h00;
          st_nxt.burst_cnt      = 2'h0;
        end
      end
      PS_WAKE: begin
        if (!cfg.psave_en) begin
          st_nxt.stat.pwr_state = PS_OFF;
        end else if (st_r.energy) begin
          st_nxt.stat.pwr_state = PS_NORM;
          st_nxt.ps_tmr         = LSTO_MS[cfg.lsto_sel];
        end else if (st_r.ps_tmr == 13'h0000) begin
          st_nxt.stat.pwr_state = PS_LOW;
          st_nxt.ps_tmr         = sleep_ld;
        end else if ((st_r.burst_tmr == 5'h00) && (st_r.burst_cnt != FLP_BURSTS)) begin
          // One burst per interval, swapping pair each time
          st_nxt.stat.wake_flp    = 1'b1;
          st_nxt.stat.wake_pair_b = ~st_r.stat.wake_pair_b;
          st_nxt.burst_cnt        = st_r.burst_cnt + 2'h1;
          st_nxt.burst_tmr        = FLP_BURST_MS;
        end
      end
      PS_NORM: begin
        if (!cfg.psave_en) begin
          st_nxt.stat.pwr_state = PS_OFF;
        end else if (!cfg.aneg_en) begin
          st_nxt.stat.pwr_state = PS_NORM;
        end else if (link) begin
          st_nxt.ps_tmr = LSTO_MS[cfg.lsto_sel];
        end else if (st_r.ps_tmr == 13'h0000) begin
          st_nxt.stat.pwr_state = PS_LOW;
          st_nxt.ps_tmr         = sleep_ld;
        end
      end
      default: st_nxt.stat.pwr_state = PS_OFF;
    endcase
  end

  // ========================================================
  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.stat.active_media <= MEDIA_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stat = st_r.stat;

  // ========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_PREF_SERDES_WINS: assert property (
    (auto_sel && cfg.pref_serdes && media.sd_link) |=> (stat.active_media == MEDIA_SERDES))
    else $error("preferred serdes link not selected");
  AST_PREF_COPPER_WINS: assert property (
    (auto_sel && !cfg.pref_serdes && media.cu_link) |=> (stat.active_media == MEDIA_COPPER) && stat.sd_block)
    else $error("preferred copper link not selected");
  AST_COPPER_BLOCKED: assert property (
    (auto_sel && cfg.pref_serdes && media.sd_link) |=> stat.cu_block && !stat.sd_block)
    else $error("copper not blocked under serdes link");
  AST_NONPREF_ALONE: assert property (
    (auto_sel && !cfg.pref_serdes && !media.cu_link && media.sd_link) |=> (stat.active_media == MEDIA_SERDES))
    else $error("lone non-preferred link not active");
  AST_NO_MEDIA: assert property (
    (!media.cu_link && !media.sd_link) |=> (stat.active_media == MEDIA_NONE) && !stat.link_status)
    else $error("no media not reported");
  AST_IPD_FOUND: assert property (
    ((st_r.ipd == IPD_SEARCH) && ipd_ok && media.flp_loopback) |=> stat.ipd_flag && (stat.ipd_status == 2'h1))
    else $error("loopback not reported");
  AST_IPD_CLEAR: assert property (
    (int_rd && !ipd_set) |=> !stat.ipd_flag)
    else $error("flag not cleared by read");
  AST_IPD_TIMEOUT: assert property (
    ((st_r.ipd == IPD_SEARCH) && ipd_ok && !media.flp_loopback && (st_r.ipd_tmr == 13'h0000))
    |=> (stat.ipd_status == 2'h2) && !stat.ipd_flp_tx ##1 stat.aneg_run)
    else $error("detection timeout not reported");
  AST_ENERGY_WAKES: assert property (
    ((stat.pwr_state == PS_LOW) && cfg.psave_en && st_r.energy) |=> (stat.pwr_state == PS_NORM))
    else $error("energy did not reach normal state");
  AST_FORCED_STAYS: assert property (
    ((stat.pwr_state == PS_NORM) && cfg.psave_en && !cfg.aneg_en) |=> $stable(stat.pwr_state))
    else $error("forced mode left normal state");
  AST_ENABLE_LOW: assert property (
    ((stat.pwr_state == PS_OFF) && cfg.psave_en) |=> (stat.pwr_state == PS_LOW))
    else $error("enable did not enter low power");
  AST_BURST_PAIR: assert property (
    stat.wake_flp |-> (stat.pwr_state == PS_WAKE) && (stat.wake_pair_b != $past(stat.wake_pair_b)))
    else $error("burst without pair swap");
  AST_IPD_RESTART: assert property (
    ((st_r.ipd == IPD_ANEG) && ipd_ok && st_r.link_seen && !media.cu_link)
    |=> stat.ipd_flp_tx && (stat.ipd_status == IPD_ST_SEARCH))
    else $error("link loss did not restart detection");
  AST_LINK_TIMEOUT: assert property (
    ((stat.pwr_state == PS_NORM) && cfg.psave_en && cfg.aneg_en && !link && (st_r.ps_tmr == 13'h0000))
    |=> (stat.pwr_state == PS_LOW))
    else $error("link timeout did not reach low power");

endmodule
`default_nettype wire

/* rtl/msp_pkg.sv */
`default_nettype none
// ==========================================================
// Shared constants and types
package msp_pkg;

  // ========================================================
  // Clock and time base
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // ========================================================
  // Media selection encodings
  localparam logic [1:0] MEDIA_COPPER  = 2'h0;
  localparam logic [1:0] MEDIA_SERDES  = 2'h1;
  localparam logic [1:0] MEDIA_NONE    = 2'h2;
  localparam logic [2:0] MODE_AUTO_ANEG = 3'h6;
  localparam logic [2:0] MODE_AUTO_PASS = 3'h5;
  localparam logic [2:0] MODE_AUTO_FX   = 3'h7;

  // ========================================================
  // Inline power detection status codes and timing
  localparam logic [1:0]  IPD_ST_SEARCH  = 2'h0;
  localparam logic [1:0]  IPD_ST_FOUND   = 2'h1;
  localparam logic [1:0]  IPD_ST_TIMEOUT = 2'h2;
  localparam logic [12:0] IPD_TIMEOUT_MS = 13'h3e8;

  // ========================================================
  // Power saving timers, in milliseconds, indexed by field
  localparam logic [12:0] SLEEP_MS [4] = '{13'h3e8, 13'h7d0, 13'hbb8, 13'hfa0};
  localparam logic [12:0] WAKE_MS  [4] = '{13'h0a0, 13'h190, 13'h320, 13'h7d0};
  localparam logic [12:0] LSTO_MS  [4] = '{13'h3e8, 13'h7d0, 13'hbb8, 13'hfa0};
  localparam logic [12:0] RAND_NEG_MS  = 13'h050;
  localparam logic [7:0]  RAND_SPAN    = 8'h8c;
  localparam logic [7:0]  RAND_FOLD    = 8'h73;
  localparam logic [7:0]  LFSR_SEED    = 8'h5a;
  localparam logic [4:0]  FLP_BURST_MS = 5'h10;
  localparam logic [1:0]  FLP_BURSTS   = 2'h3;

  // ========================================================
  // Types
  typedef enum logic [1:0] {
    PS_OFF  = 2'b00,
    PS_LOW  = 2'b01,
    PS_WAKE = 2'b10,
    PS_NORM = 2'b11
  } msp_ps_e_t;

  typedef enum logic [1:0] {
    IPD_OFF    = 2'b00,
    IPD_SEARCH = 2'b01,
    IPD_FOUND  = 2'b10,
    IPD_ANEG   = 2'b11
  } msp_ipd_e_t;

  typedef struct packed {
    logic       pref_serdes;
    logic [2:0] media_mode;
    logic       aneg_en;
    logic       ipd_en;
    logic       psave_en;
    logic [1:0] sleep_sel;
    logic [1:0] wake_sel;
    logic [1:0] lsto_sel;
  } msp_cfg_t;

  typedef struct packed {
    logic cu_link;
    logic sd_link;
    logic flp_loopback;
  } msp_media_t;

  typedef struct packed {
    logic [1:0] active_media;
    logic       cu_block;
    logic       sd_block;
    logic       regs_both;
    logic       link_status;
    logic [1:0] ipd_status;
    logic       ipd_flag;
    logic       ipd_flp_tx;
    logic       aneg_run;
    msp_ps_e_t  pwr_state;
    logic       wake_flp;
    logic       wake_pair_b;
  } msp_stat_t;

endpackage
`default_nettype wire

/* rtl/msp_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Millisecond tick and free-running random offset
module msp_tick_gen #(
  parameter int MS_CYCLES = msp_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Time base and random value
  output logic            ms_tick,
  output logic [7:0]      rnd
);
  import msp_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
    logic [7:0]  lfsr;
  } msp_tick_st_t;

  msp_tick_st_t st_r;
  msp_tick_st_t st_nxt;

  // Prescaler and LFSR, stepping every cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.lfsr = {st_r.lfsr[6:0], st_r.lfsr[7] ^ st_r.lfsr[5] ^ st_r.lfsr[4] ^ st_r.lfsr[3]};
    if (st_r.cnt == 16'(MS_CYCLES - 1)) begin
      st_nxt.cnt  = 16'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{cnt: 16'h0000, tick: 1'b0, lfsr: LFSR_SEED};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Fold into 0..140 so the offset spans -80..+60 ms
  assign ms_tick = st_r.tick;
  assign rnd     = (st_r.lfsr > RAND_SPAN) ? (st_r.lfsr - RAND_FOLD) : st_r.lfsr;

endmodule
`default_nettype wire
